// >>> design/cantrx_core.sv
// Purpose: mode, wake and diagnosis logic of a high speed can transceiver
// Assumes: all inputs synchronous to sys_clk_i; bus level 0 is dominant
// Notes:   a two-entry buffer carries tx/bus bits; once a stalled rx side lets it fill, new bits are dropped
// ============================================================
// Notes on behaviour
// [RULE1] in normal mode every transmit level goes to the bus and the bus level comes back on rx.
// [RULE2] in receive-only mode the driver is off, transmit is blocked, receive and diagnosis run.
// [RULE3] the protocol controller keeps bit times of at least one microsecond.
// [RULE4] when unpowered the driver and receiver termination are high impedance.
// [RULE5] wake detection runs only while the wake strap is tied to the standby supply.
// [RULE6] with the strap at ground no wake event is ever raised.
// [RULE7] in system sleep a dominant longer than the filter time after recessive sets the wake flag.
// [RULE8] writing one to the wake-clear bit resets the wake flag, whose value is readable.
// [RULE9] after a clear only a fresh recessive-to-dominant edge may wake again.
// [RULE10] bus failure detection runs in normal operation; shorts and opens are not reported.
// [RULE11] a bus dominant longer than the detection time sets the clamp flag.
// [RULE12] a transmit input dominant longer than the detection time sets the time-out flag.
// [RULE13] detected overtemperature sets the overtemperature flag.
// [RULE14] a failure changes only its own flag and never the mode or other settings.
// [RULE15] the dominant detectors restart on recessive and need one unbroken interval.
// [RULE16] the wake flag stays set until the wake-clear bit is written.
`timescale 1ns/1ps
`include "cantrx_cfg.svh"

module cantrx_core
  import cantrx_pkg::*;
#(
  parameter int DOM_CYC  = `CANTRX_DOM_CYC,
  parameter int WAKE_CYC = `CANTRX_WAKE_CYC,
  parameter int BUF_W    = 2
) (
  input  wire logic         sys_clk_i,
  input  wire logic         nrst_i,
  input  wire cantrx_mode_t mode_i,
  input  wire logic         supply_ok_i,
  input  wire logic         tx_serial_input_i,
  input  wire logic         bus_level_i,
  input  wire logic         wake_enable_strap_i,
  input  wire logic         system_sleep_state_i,
  input  wire logic         wake_clear_bit_i,
  input  wire logic         overtemp_i,
  input  wire logic         diag_clear_i,
  input  wire logic         rx_ready_i,
  output logic              tx_ready_o,
  output logic              rx_valid_o,
  output logic              rx_serial_output_o,
  output logic              bus_drive_dom_o,
  output logic              bus_drive_oe_o,
  output logic              rx_term_en_o,
  output logic              remote_wake_flag_o,
  output cantrx_diag_t      communication_diag_register_o,
  output cantrx_mode_t      operating_mode_o
);

  localparam int CW = $clog2(DOM_CYC + 1);
  localparam int WW = $clog2(WAKE_CYC + 1);

  // ============================================================
  // mode and strap capture
  cantrx_mode_t mode;
  logic         strap;
  logic         in_pwrdn;

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      mode <= CANTRX_MODE_RXONLY;
    end else begin
      mode <= mode_i; // diagnosis never writes here, see [RULE14]
    end
  end

  always_ff @(posedge sys_clk_i) begin
    strap <= wake_enable_strap_i; // sampled each cycle, see [RULE5]
  end

  assign in_pwrdn = (mode == CANTRX_MODE_PWRDN) || !supply_ok_i;

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      operating_mode_o <= CANTRX_MODE_RXONLY;
    end else begin
      operating_mode_o <= mode;
    end
  end

  // ============================================================
  // two-entry buffer on the data path
  cantrx_bits_t buf_q [2];
  logic [1:0]   wr_ptr;
  logic [1:0]   rd_ptr;
  logic [1:0]   count;
  logic         push;
  logic         pop;
  cantrx_bits_t head;

  assign push = (count != 2'h2);
  assign pop  = rx_valid_o && rx_ready_i;
  assign head = buf_q[rd_ptr[0]];

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      buf_q[wr_ptr[0]] <= '{bus_level: bus_level_i, tx_level: tx_serial_input_i};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      wr_ptr <= 2'h0;
      rd_ptr <= 2'h0;
      count  <= 2'h0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 2'h1;
      if (pop)  rd_ptr <= rd_ptr + 2'h1;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      tx_ready_o <= 1'b1;
      rx_valid_o <= 1'b0;
    end else begin
      tx_ready_o <= (count + {1'b0, push} - {1'b0, pop}) != 2'h2;
      rx_valid_o <= (count + {1'b0, push} - {1'b0, pop}) != 2'h0;
    end
  end

  // ============================================================
  // driver and receiver
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      bus_drive_dom_o    <= 1'b0;
      bus_drive_oe_o     <= 1'b0;
      rx_term_en_o       <= 1'b0;
      rx_serial_output_o <= `CANTRX_RECESSIVE;
    end else begin
      // only normal mode drives; rx-only and power down block tx, see [RULE1] [RULE2]
      bus_drive_oe_o  <= (mode == CANTRX_MODE_NORMAL) && !in_pwrdn;
      bus_drive_dom_o <= (mode == CANTRX_MODE_NORMAL) && !in_pwrdn &&
                         (tx_serial_input_i == `CANTRX_DOMINANT);
      rx_term_en_o    <= !in_pwrdn; // high impedance when unsupplied, see [RULE4]
      if (pop) begin
        rx_serial_output_o <= head.bus_level; // see [RULE1] [RULE2]
      end
    end
  end

  // ============================================================
  // dominant detectors, restart on recessive
  logic [CW-1:0] bus_cnt;
  logic [CW-1:0] tx_cnt;
  logic          diag_on;

  // failure detection in normal and receive-only, see [RULE10] [RULE2]
  assign diag_on = !in_pwrdn;

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i || !diag_on || bus_level_i == `CANTRX_RECESSIVE) begin
      bus_cnt <= '0; // see [RULE15]
    end else if (bus_cnt != CW'(DOM_CYC)) begin
      bus_cnt <= bus_cnt + CW'(1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i || !diag_on || tx_serial_input_i == `CANTRX_RECESSIVE) begin
      tx_cnt <= '0; // see [RULE15]
    end else if (tx_cnt != CW'(DOM_CYC)) begin
      tx_cnt <= tx_cnt + CW'(1);
    end
  end

  // set wins over clear for every flag
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      communication_diag_register_o <= '0;
    end else begin
      // flag needs one more dominant sample beyond the count: strictly longer, see [RULE15]
      communication_diag_register_o.bus_dominant_clamp_flag <=
        ((bus_cnt == CW'(DOM_CYC)) && diag_on && (bus_level_i == `CANTRX_DOMINANT)) ||
        (communication_diag_register_o.bus_dominant_clamp_flag && !diag_clear_i); // see [RULE11]
      communication_diag_register_o.tx_dominant_timeout_flag <=
        ((tx_cnt == CW'(DOM_CYC)) && diag_on && (tx_serial_input_i == `CANTRX_DOMINANT)) ||
        (communication_diag_register_o.tx_dominant_timeout_flag && !diag_clear_i); // see [RULE12]
      communication_diag_register_o.transceiver_overtemp_flag <=
        (overtemp_i && diag_on) ||
        (communication_diag_register_o.transceiver_overtemp_flag && !diag_clear_i); // see [RULE13]
    end
  end

  // ============================================================
  // remote wake state machine
  cantrx_wake_t  wk_state;
  logic [WW-1:0] wk_cnt;
  logic          wk_on;
  logic          wk_set;

  assign wk_on  = strap && system_sleep_state_i; // see [RULE5] [RULE6]
  // a bus gone recessive on the last sample must not wake, see [RULE7]
  assign wk_set = (wk_state == CANTRX_WK_FILTER) && (wk_cnt == WW'(WAKE_CYC)) &&
                  wk_on && (bus_level_i == `CANTRX_DOMINANT);

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      wk_state <= CANTRX_WK_IDLE;
      wk_cnt   <= '0;
    end else begin
      unique case (wk_state)
        CANTRX_WK_IDLE: begin
          wk_cnt <= '0;
          // arm only after a recessive bus, see [RULE7] [RULE9]
          if (wk_on && bus_level_i == `CANTRX_RECESSIVE) wk_state <= CANTRX_WK_ARMED;
        end
        CANTRX_WK_ARMED: begin
          wk_cnt <= '0;
          if (!wk_on) wk_state <= CANTRX_WK_IDLE;
          else if (bus_level_i == `CANTRX_DOMINANT) wk_state <= CANTRX_WK_FILTER;
        end
        CANTRX_WK_FILTER: begin
          if (!wk_on) begin
            wk_state <= CANTRX_WK_IDLE;
          end else if (bus_level_i == `CANTRX_RECESSIVE) begin
            wk_state <= CANTRX_WK_ARMED;
          end else if (wk_set) begin
            wk_state <= CANTRX_WK_LATCHED; // see [RULE7]
          end else begin
            wk_cnt <= wk_cnt + WW'(1);
          end
        end
        CANTRX_WK_LATCHED: begin
          // held dominant bus cannot re-wake: clear returns to idle, see [RULE9]
          if (wake_clear_bit_i) wk_state <= CANTRX_WK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      remote_wake_flag_o <= 1'b0;
    end else begin
      // sticky until cleared, set wins, see [RULE8] [RULE16]
      remote_wake_flag_o <= wk_set || (remote_wake_flag_o && !wake_clear_bit_i);
    end
  end

endmodule

// >>> design/cantrx_cfg.svh
// Purpose: timing constants for the can transceiver control block
// Assumes: 40 MHz system clock
// Notes:   counts derived from times in their own units
`ifndef CANTRX_CFG_SVH
`define CANTRX_CFG_SVH
`define CANTRX_CLK_MHZ          40
`define CANTRX_CLK_KHZ          40000
// wake filter window, tenths of a microsecond
`define CANTRX_WAKE_MIN_X10US   8
`define CANTRX_WAKE_MAX_X10US   50
// dominant detection window, milliseconds
`define CANTRX_DOM_MIN_MS       4
`define CANTRX_DOM_MAX_MS       7
// wake filter: 0.75 us rounded up, below the 0.8 us least time -> 30 cycles
`define CANTRX_WAKE_CYC         ((75 * `CANTRX_CLK_MHZ + 99) / 100)
// dominant detection: least time 4 ms
`define CANTRX_DOM_CYC          (`CANTRX_DOM_MIN_MS * `CANTRX_CLK_KHZ)
`define CANTRX_RECESSIVE        1'b1
`define CANTRX_DOMINANT         1'b0
`endif

// >>> design/cantrx_pkg.sv
// Purpose: shared types for the can transceiver control block
// Assumes: nothing
// Notes:   mode codes are gray along normal -> receive only -> power down
package cantrx_pkg;
  typedef enum logic [1:0] {
    CANTRX_MODE_NORMAL  = 2'b00,
    CANTRX_MODE_RXONLY  = 2'b01,
    CANTRX_MODE_PWRDN   = 2'b11
  } cantrx_mode_t;

  typedef enum logic [1:0] {
    CANTRX_WK_IDLE      = 2'b00,
    CANTRX_WK_ARMED     = 2'b01,
    CANTRX_WK_FILTER    = 2'b11,
    CANTRX_WK_LATCHED   = 2'b10
  } cantrx_wake_t;

  typedef struct packed {
    logic bus_dominant_clamp_flag;
    logic tx_dominant_timeout_flag;
    logic transceiver_overtemp_flag;
  } cantrx_diag_t;

  typedef struct packed {
    logic bus_level;
    logic tx_level;
  } cantrx_bits_t;
endpackage

// >>> dv/cantrx_chk.sv
// Purpose: port timing checks for the can transceiver core
// Assumes: counts handed on from the core instance
// Notes: run counters do not saturate; bench runs stay short
`timescale 1ns/1ps
module cantrx_chk
  import cantrx_pkg::*;
#(
  parameter int DOM_CYC  = 100,
  parameter int WAKE_CYC = 4
) (
  input wire logic         sys_clk_i,
  input wire logic         nrst_i,
  input wire cantrx_mode_t mode_i,
  input wire logic         supply_ok_i,
  input wire logic         tx_serial_input_i,
  input wire logic         bus_level_i,
  input wire logic         wake_enable_strap_i,
  input wire logic         system_sleep_state_i,
  input wire logic         wake_clear_bit_i,
  input wire logic         bus_drive_dom_o,
  input wire logic         bus_drive_oe_o,
  input wire logic         rx_term_en_o,
  input wire logic         remote_wake_flag_o,
  input wire cantrx_diag_t communication_diag_register_o
);
  logic [15:0] bus_run;
  logic [15:0] tx_run;
  logic [15:0] wk_run;
  logic        rec_seen;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // lower bounds only: the core may count from a later start
  always_ff @(posedge sys_clk_i) begin
    bus_run  <= (!nrst_i || bus_level_i) ? 16'h0000 : bus_run + 16'h0001;
    tx_run   <= (!nrst_i || tx_serial_input_i) ? 16'h0000 : tx_run + 16'h0001;
    wk_run   <= (!nrst_i || bus_level_i || !wake_enable_strap_i || !system_sleep_state_i) ?
                16'h0000 : wk_run + 16'h0001;
    rec_seen <= nrst_i && !wake_clear_bit_i && (rec_seen || bus_level_i);
  end
  a_tx_echo: assert property (
    (mode_i == CANTRX_MODE_NORMAL && supply_ok_i)[*3] |=> bus_drive_oe_o &&
      (bus_drive_dom_o == !$past(tx_serial_input_i))) else $error("tx not on bus");
  a_unpowered_hiz: assert property (
    (!supply_ok_i)[*3] |-> !bus_drive_oe_o && !rx_term_en_o) else $error("bus disturbed");
  a_wake_filter: assert property (
    $rose(remote_wake_flag_o) |-> wk_run >= WAKE_CYC + 1) else $error("wake too early");
  a_wake_sticky: assert property (
    remote_wake_flag_o && !wake_clear_bit_i |=> remote_wake_flag_o) else $error("wake lost");
  a_wake_clear: assert property (
    wake_clear_bit_i && remote_wake_flag_o |=> !remote_wake_flag_o) else $error("no clear");
  a_wake_fresh: assert property (
    $rose(remote_wake_flag_o) |-> rec_seen) else $error("wake without recessive");
  a_clamp_time: assert property (
    $rose(communication_diag_register_o.bus_dominant_clamp_flag) |-> bus_run >= DOM_CYC + 1)
    else $error("clamp flag early");
  a_txto_time: assert property (
    $rose(communication_diag_register_o.tx_dominant_timeout_flag) |-> tx_run >= DOM_CYC + 1)
    else $error("tx timeout early");
endmodule

// >>> dv/cantrx_ctl_model.sv
// Purpose: protocol controller stand-in
// Assumes: one bit time is BIT_CYC clocks
// Notes: stall_i holds off reception on command
`timescale 1ns/1ps
module cantrx_ctl_model #(
  parameter int BIT_CYC = 40
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic bit_i,
  input  wire logic stall_i,
  output logic      tx_o,
  output logic      rx_ready_o
);
  int cnt;
  assign rx_ready_o = !stall_i;
  // bits only change at bit-time boundaries
  always_ff @(posedge clk_i) begin
    cnt  <= (!nrst_i || cnt == BIT_CYC - 1) ? 0 : cnt + 1;
    tx_o <= !nrst_i ? 1'b1 : (cnt == BIT_CYC - 1) ? bit_i : tx_o;
  end
endmodule

// >>> dv/tb_top.sv
// Purpose: self-checking bench for the can transceiver core
// Assumes: 40 MHz clock; inputs move on the falling edge
// Notes: detection counts shortened through parameters
`timescale 1ns/1ps
module tb_top;
  import cantrx_pkg::*;
  localparam int DC = 100;
  localparam int WC = 4;
  logic clk = 1'b0, nrst = 1'b0, sup = 1'b1, strap = 1'b0, slp = 1'b0, wclr = 1'b0;
  logic ot = 1'b0, dclr = 1'b0, dom = 1'b0, stall = 1'b0, bit_v = 1'b1;
  logic tx, rdy, trdy, rvld, rxo, ddom, doe, term, wk, bus;
  cantrx_mode_t mode = CANTRX_MODE_NORMAL;
  cantrx_mode_t opm;
  cantrx_diag_t diag;
  int error_cnt = 0;
  int checks_done = 0;
  int seed = 83;
  always #12.5 clk = ~clk;
  // wired bus: any dominant driver wins
  assign bus = !(dom || (doe && ddom));
  cantrx_core #(.DOM_CYC(DC), .WAKE_CYC(WC)) DUT (.sys_clk_i(clk), .nrst_i(nrst), .mode_i(mode),
    .supply_ok_i(sup), .tx_serial_input_i(tx), .bus_level_i(bus), .wake_enable_strap_i(strap),
    .system_sleep_state_i(slp), .wake_clear_bit_i(wclr), .overtemp_i(ot), .diag_clear_i(dclr),
    .rx_ready_i(rdy), .tx_ready_o(trdy), .rx_valid_o(rvld), .rx_serial_output_o(rxo),
    .bus_drive_dom_o(ddom), .bus_drive_oe_o(doe), .rx_term_en_o(term), .remote_wake_flag_o(wk),
    .communication_diag_register_o(diag), .operating_mode_o(opm));
  cantrx_ctl_model u_ctl (.clk_i(clk), .nrst_i(nrst), .bit_i(bit_v), .stall_i(stall),
    .tx_o(tx), .rx_ready_o(rdy));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // expected {oe, dom, rx} for a settled transmit bit in normal mode
  function automatic logic [7:0] exp_drive(input logic b);
    return {5'h00, 1'b1, !b, b};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    cyc(16);
    chk({trdy, rxo, opm, wk, diag}, 8'hd0);
    nrst = 1'b1;
    for (int i = 0; i < 20; i++) begin
      bit_v = 1'($random(seed));
      stall = 1'($random(seed));
      cyc(60);
      if (stall) begin
        chk({trdy, rvld}, 8'h01);
      end
      stall = 1'b0;
      cyc(20);
      chk({doe, ddom, rxo}, exp_drive(bit_v));
    end
    bit_v = 1'b1;
    cyc(80);
    for (int m = 0; m < 3; m++) begin
      mode = (m == 0) ? CANTRX_MODE_NORMAL : (m == 1) ? CANTRX_MODE_RXONLY : CANTRX_MODE_PWRDN;
      cyc(4);
      chk({doe, term}, {6'h00, m == 0, m != 2});
    end
    mode = CANTRX_MODE_NORMAL;
    sup = 1'b0;
    cyc(4);
    chk({doe, term}, 8'h00);
    sup = 1'b1;
    pulse(dclr);
    mode = CANTRX_MODE_RXONLY;
    bit_v = 1'b0;
    cyc(80);
    chk({bus, diag}, 8'h08);
    cyc(80);
    chk({opm, diag}, {3'h0, CANTRX_MODE_RXONLY, 3'b010});
    bit_v = 1'b1;
    cyc(80);
    pulse(dclr);
    dom = 1'b1;
    cyc(DC - 10);
    dom = 1'b0;
    cyc(1);
    dom = 1'b1;
    cyc(DC - 10);
    chk(diag, 8'h00);
    cyc(20);
    pulse(ot);
    cyc(1);
    chk({opm, diag}, {3'h0, CANTRX_MODE_RXONLY, 3'b101});
    dom = 1'b0;
    strap = 1'b1;
    slp = 1'b1;
    cyc(5);
    dom = 1'b1;
    cyc(WC);
    dom = 1'b0;
    cyc(3);
    chk(wk, 8'h00);
    dom = 1'b1;
    cyc(WC + 6);
    dom = 1'b0;
    cyc(5);
    chk(wk, 8'h01);
    dom = 1'b1;
    pulse(wclr);
    cyc(3 * WC + 10);
    chk(wk, 8'h00);
    dom = 1'b0;
    cyc(3);
    dom = 1'b1;
    cyc(WC + 6);
    chk(wk, 8'h01);
    pulse(wclr);
    strap = 1'b0;
    dom = 1'b0;
    cyc(3);
    dom = 1'b1;
    cyc(WC + 6);
    chk(wk, 8'h00);
    give_verdict();
  end
endmodule
bind cantrx_core cantrx_chk #(.DOM_CYC(DOM_CYC), .WAKE_CYC(WAKE_CYC)) u_chk (.*);
